// ---- src/fbm_pkg.sv ----
// Purpose: shared constants and types of the flash bus mode host
// Assumes: 100 MHz clk, asynchronous parallel flash on the far side
// Notes:   pin timings are plain defaults; set them from the part in use

package fbm_pkg;

  // ==========================================================
  // widths and clock
  localparam int ADDR_W   = 22;
  localparam int DATA_W   = 16;
  localparam int CLK_NS   = 10;
  localparam int SYNC_LAT = 5; // three stages, agree edge, one edge of sampling slack

  // ==========================================================
  // pin timing, in ns, then in whole cycles rounded up
  localparam int SELECT_ACCESS_NS  = 70;
  localparam int WE_LOW_NS         = 40;
  localparam int WE_HIGH_NS        = 20;
  localparam int RESET_PULSE_NS    = 500;
  localparam int RESET_RECOVERY_NS = 50;
  localparam int BUSY_VALID_NS     = 100;

  localparam int SELECT_ACCESS_CYC  = (SELECT_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC         = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC        = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_CYC    = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_VALID_CYC     = (BUSY_VALID_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // sequence lengths in write cycles
  localparam int PROG_LEN     = 4;
  localparam int PROG_BYP_LEN = 2;
  localparam int ERASE_LEN    = 6;
  localparam int ENTRY_LEN    = 3;

  // ==========================================================
  // operations and controller states
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_WRITE      = 4'h1,
    OP_PROG       = 4'h2,
    OP_ERASE_SECT = 4'h3,
    OP_ERASE_ADD  = 4'h4,
    OP_ERASE_CHIP = 4'h5,
    OP_BYPASS     = 4'h6,
    OP_AUTOSEL    = 4'h7,
    OP_RESET      = 4'h8
  } fbm_op_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_CHK    = 3'b001,
    S_WSET   = 3'b010,
    S_WLO    = 3'b011,
    S_WHI    = 3'b100,
    S_RD     = 3'b101,
    S_BUSY   = 3'b110,
    S_RST    = 3'b111
  } fbm_state_t;

endpackage

// ---- src/fbm_sync_if.sv ----
// Purpose: carries raw pin levels to the synchroniser and clean ones back
// Assumes: one clock domain on the controller side
// Notes:   none

interface fbm_sync_if #(parameter int W = 17);
  logic [W-1:0] raw;
  logic [W-1:0] val;
  modport owner (output raw, input val);
  modport sync  (input raw, output val);
endinterface

// ---- src/fbm_pin_sync.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs change asynchronously to clk
// Notes:   clean value starts low, which reads as busy until settled

module fbm_pin_sync
  import fbm_pkg::*;
#(
  parameter int W = 17
) (
  input wire logic clk,
  input wire logic rst,
  fbm_sync_if.sync p
);

  // ==========================================================
  // per-bit stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r, s2_r, s3_r, v_r;
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          v_r  <= 1'b0;
        end else begin
          s1_r <= p.raw[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // a level counts only once two later stages agree
          if (s2_r == s3_r) begin
            v_r <= s3_r;
          end
        end
      end
      assign p.val[i] = v_r;
    end
  endgenerate

endmodule

// ---- src/fbm_host.sv ----
// Purpose: host controller driving a parallel NOR flash through its pins
// Assumes: one op per request; command words given as parameters
// Notes:   reads while a program or erase runs wait for ready
//
// Contract
// - command write cycles: write strobe and select low, output gate high.
// - while accelerating, host programs with the two-cycle bypass sequence.
// - autoselect reads use ordinary read timing.
// - host waits the full select access time before taking read data.
// - host waits the recovery time after reset rises before reading.
// - host should re-issue a program or erase cut short by reset; fbm_host does not re-issue, it only raises reissue_hint.

module fbm_host
  import fbm_pkg::*;
#(
  parameter int          AW        = ADDR_W,
  parameter int          DW        = DATA_W,
  parameter logic [21:0] UNLK1_A   = 22'h000001,
  parameter logic [15:0] UNLK1_D   = 16'h0001,
  parameter logic [21:0] UNLK2_A   = 22'h000002,
  parameter logic [15:0] UNLK2_D   = 16'h0002,
  parameter logic [15:0] PROG_D    = 16'h0003,
  parameter logic [15:0] ERASE_D   = 16'h0004,
  parameter logic [15:0] SECT_D    = 16'h0005,
  parameter logic [15:0] CHIP_D    = 16'h0006,
  parameter logic [15:0] BYPASS_D  = 16'h0007,
  parameter logic [15:0] AUTOSEL_D = 16'h0008
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic [3:0]    cmd_op,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [DW-1:0] cmd_data,
  input  wire logic          accel_req,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_data,
  output logic               autosel_active,
  output logic               reissue_hint,
  output logic               accel_high_voltage_en,
  output logic [AW-1:0]      flash_addr,
  output logic               lower_half_select_n,
  output logic               output_gate_n,
  output logic               write_strobe_n,
  output logic               reset_n,
  output logic [DW-1:0]      dq_o,
  output logic               dq_oe,
  input  wire logic [DW-1:0] dq_i,
  input  wire logic          ready_busy_n
);

  // ==========================================================
  // state
  typedef struct packed {
    fbm_state_t    st;
    fbm_op_t       op;
    logic [2:0]    step;
    logic [15:0]   cnt;
    logic [AW-1:0] ca;
    logic [DW-1:0] cd;
    logic          bypass;
    logic          autosel;
    logic          running;
    logic          intr;
    logic          accel;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic          rst_n;
    logic          dq_oe;
    logic [AW-1:0] a;
    logic [DW-1:0] dq;
    logic          ready;
    logic          rv;
    logic [DW-1:0] rd;
  } fbm_host_st_t;

  typedef struct packed {
    logic          last;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
  } fbm_word_t;

  fbm_host_st_t s_r, s_nxt;
  fbm_word_t    w;
  logic         byp_eff;
  logic         rb_s;
  logic [DW-1:0] dq_s;

  fbm_sync_if #(.W(DW + 1)) sy ();
  assign sy.raw = {ready_busy_n, dq_i};
  assign {rb_s, dq_s} = sy.val;

  fbm_pin_sync #(.W(DW + 1)) i_fbm_pin_sync (
    .clk (clk),
    .rst (rst),
    .p   (sy)
  );

  // ==========================================================
  // command word for a given step
  function automatic fbm_word_t seq_word(input fbm_op_t op, input logic [2:0] st,
                                         input logic byp, input logic [AW-1:0] ad,
                                         input logic [DW-1:0] dd);
    fbm_word_t r;
    logic [AW-1:0] u1, u2;
    r  = '0;
    u1 = AW'(UNLK1_A);
    u2 = AW'(UNLK2_A);
    case (st)
      3'd0:    r = '{1'b0, u1, DW'(UNLK1_D)};
      3'd1:    r = '{1'b0, u2, DW'(UNLK2_D)};
      3'd3:    r = '{1'b0, u1, DW'(UNLK1_D)};
      3'd4:    r = '{1'b0, u2, DW'(UNLK2_D)};
      default: r = '{1'b0, u1, DW'(ERASE_D)};
    endcase
    case (op)
      OP_WRITE, OP_ERASE_ADD: r = '{1'b1, ad, (op == OP_WRITE) ? dd : DW'(SECT_D)};
      OP_PROG: begin
        if (byp) begin
          r = (st == 3'd0) ? '{1'b0, ad, DW'(PROG_D)} : '{1'b1, ad, dd};
        end else if (st == 3'd2) begin
          r = '{1'b0, u1, DW'(PROG_D)};
        end else if (st == 3'd3) begin
          r = '{1'b1, ad, dd};
        end
      end
      OP_ERASE_SECT: if (st == 3'd5) r = '{1'b1, ad, DW'(SECT_D)};
      OP_ERASE_CHIP: if (st == 3'd5) r = '{1'b1, u1, DW'(CHIP_D)};
      OP_BYPASS:     if (st == 3'd2) r = '{1'b1, u1, DW'(BYPASS_D)};
      OP_AUTOSEL:    if (st == 3'd2) r = '{1'b1, u1, DW'(AUTOSEL_D)};
      default:       r = r;
    endcase
    return r;
  endfunction

  assign byp_eff = s_r.bypass | s_r.accel;
  assign w       = seq_word(s_r.op, s_r.step, byp_eff, s_r.ca, s_r.cd);

  // ==========================================================
  // next state
  always_comb begin
    s_nxt    = s_r;
    s_nxt.rv = 1'b0;
    if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
    case (s_r.st)
      S_IDLE: begin
        // accelerate level only moves between ops, never mid-sequence
        if (!s_r.running) begin
          s_nxt.accel = accel_req;
        end
        if (cmd_valid) begin
          s_nxt.op   = fbm_op_t'(cmd_op);
          s_nxt.ca   = cmd_addr;
          s_nxt.cd   = cmd_data;
          s_nxt.step = 3'd0;
          s_nxt.intr = 1'b0;
          s_nxt.st   = S_CHK;
        end
      end
      S_CHK: begin
        if (s_r.running && s_r.op != OP_ERASE_ADD && s_r.op != OP_RESET) begin
          s_nxt.st  = S_BUSY;
          s_nxt.cnt = 16'(BUSY_VALID_CYC + SYNC_LAT);
        end else if (s_r.op == OP_RESET) begin
          s_nxt.st    = S_RST;
          s_nxt.rst_n = 1'b0;
          s_nxt.ce_n  = 1'b1;
          s_nxt.oe_n  = 1'b1;
          s_nxt.cnt   = 16'(RESET_PULSE_CYC);
        end else if (s_r.op == OP_READ) begin
          s_nxt.st   = S_RD;
          s_nxt.a    = s_r.ca;
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = 1'b0;
          s_nxt.cnt  = 16'(SELECT_ACCESS_CYC + SYNC_LAT);
        end else begin
          s_nxt.st    = S_WSET;
          s_nxt.a     = w.a;
          s_nxt.dq    = w.d;
          s_nxt.dq_oe = 1'b1;
          s_nxt.ce_n  = 1'b0;
          s_nxt.oe_n  = 1'b1;
          s_nxt.cnt   = 16'h0001;
        end
      end
      S_WSET: if (s_r.cnt == 16'h0001) begin
        s_nxt.st   = S_WLO;
        s_nxt.we_n = 1'b0;
        s_nxt.cnt  = 16'(WE_LOW_CYC);
      end
      S_WLO: if (s_r.cnt == 16'h0001) begin
        s_nxt.st    = S_WHI;
        s_nxt.we_n  = 1'b1;
        s_nxt.ce_n  = 1'b1;
        s_nxt.dq_oe = 1'b0;
        s_nxt.cnt   = 16'(WE_HIGH_CYC);
      end
      S_WHI: if (s_r.cnt == 16'h0001) begin
        if (w.last) begin
          s_nxt.st = S_IDLE;
          if (s_r.op == OP_PROG || s_r.op == OP_ERASE_SECT ||
              s_r.op == OP_ERASE_CHIP || s_r.op == OP_ERASE_ADD) begin
            s_nxt.running = 1'b1;
          end
          if (s_r.op == OP_BYPASS) s_nxt.bypass = 1'b1;
          if (s_r.op == OP_AUTOSEL) s_nxt.autosel = 1'b1;
        end else begin
          s_nxt.step = s_r.step + 3'd1;
          s_nxt.st   = S_CHK;
        end
      end
      S_RD: if (s_r.cnt == 16'h0001) begin
        s_nxt.rv   = 1'b1;
        s_nxt.rd   = dq_s;
        s_nxt.ce_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.st   = S_IDLE;
      end
      S_BUSY: if (s_r.cnt == 16'h0000 && rb_s) begin
        // select stays high meanwhile; the device finishes on its own
        s_nxt.running = 1'b0;
        s_nxt.st      = S_CHK;
      end
      S_RST: begin
        if (!s_r.rst_n) begin
          if (s_r.cnt == 16'h0001) begin
            s_nxt.rst_n   = 1'b1;
            s_nxt.cnt     = 16'(RESET_RECOVERY_CYC + SYNC_LAT);
            s_nxt.intr    = s_r.running;
            s_nxt.running = 1'b0;
            s_nxt.bypass  = 1'b0;
            s_nxt.autosel = 1'b0;
          end
        end else if (!rb_s) begin
          s_nxt.cnt = 16'(RESET_RECOVERY_CYC + SYNC_LAT);
        end else if (s_r.cnt == 16'h0000) begin
          s_nxt.st = S_IDLE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
    s_nxt.ready = (s_nxt.st == S_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= S_IDLE;
      s_r.ce_n  <= 1'b1;
      s_r.oe_n  <= 1'b1;
      s_r.we_n  <= 1'b1;
      s_r.rst_n <= 1'b1;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign cmd_ready             = s_r.ready;
  assign rsp_valid             = s_r.rv;
  assign rsp_data              = s_r.rd;
  assign autosel_active        = s_r.autosel;
  assign reissue_hint          = s_r.intr;
  assign accel_high_voltage_en = s_r.accel;
  assign flash_addr            = s_r.a;
  assign lower_half_select_n   = s_r.ce_n;
  assign output_gate_n         = s_r.oe_n;
  assign write_strobe_n        = s_r.we_n;
  assign reset_n               = s_r.rst_n;
  assign dq_o                  = s_r.dq;
  assign dq_oe                 = s_r.dq_oe;

  // ==========================================================
  // checks
  logic [3:0]  wcnt_r;
  logic [15:0] celo_r, rlo_r, since_r;
  logic        byp_acc_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      wcnt_r    <= 4'h0;
      celo_r    <= 16'h0000;
      rlo_r     <= 16'h0000;
      since_r   <= 16'hFFFF;
      byp_acc_r <= 1'b0;
    end else begin
      if (s_r.st == S_IDLE && cmd_valid) begin
        wcnt_r <= 4'h0;
        byp_acc_r <= byp_eff;
      end else if (s_nxt.st == S_WLO && s_r.st == S_WSET) begin
        wcnt_r <= wcnt_r + 4'h1;
      end
      celo_r  <= (!s_r.ce_n && !s_r.oe_n) ? celo_r + 16'h0001 : 16'h0000;
      rlo_r   <= !s_r.rst_n ? rlo_r + 16'h0001 : 16'h0000;
      since_r <= !s_r.rst_n ? 16'h0000 : (since_r == 16'hFFFF ? since_r : since_r + 16'h0001);
    end
  end

  a_write_pin_levels: assert property (@(posedge clk) disable iff (rst)
    !write_strobe_n |-> !lower_half_select_n && output_gate_n && dq_oe) else $error("write cycle pin levels");
  a_prog_cycle_count: assert property (@(posedge clk) disable iff (rst)
    $rose(cmd_ready) && s_r.op == OP_PROG && $past(s_r.st) == S_WHI |-> wcnt_r == (byp_acc_r ? 4'd2 : 4'd4))
    else $error("program sequence length");
  a_accel_two_cycle: assert property (@(posedge clk) disable iff (rst)
    $rose(cmd_ready) && s_r.op == OP_PROG && s_r.accel && $past(s_r.st) == S_WHI |-> wcnt_r == 4'd2)
    else $error("accelerated program not two cycles");
  a_erase_cycle_count: assert property (@(posedge clk) disable iff (rst)
    $rose(cmd_ready) && (s_r.op == OP_ERASE_SECT || s_r.op == OP_ERASE_CHIP) && $past(s_r.st) == S_WHI
    |-> wcnt_r == 4'd6) else $error("erase sequence length");
  a_read_access_wait: assert property (@(posedge clk) disable iff (rst)
    rsp_valid |-> $past(celo_r) >= 16'(SELECT_ACCESS_CYC)) else $error("read taken too early");
  a_reset_pulse_min: assert property (@(posedge clk) disable iff (rst)
    $rose(reset_n) |-> $past(rlo_r) >= 16'(RESET_PULSE_CYC - 1)) else $error("reset pulse too short");
  a_reset_bus_quiet: assert property (@(posedge clk) disable iff (rst)
    !reset_n |-> lower_half_select_n && write_strobe_n && output_gate_n) else $error("bus active in reset");
  a_reset_recovery: assert property (@(posedge clk) disable iff (rst)
    $fell(lower_half_select_n) |-> since_r > 16'(RESET_RECOVERY_CYC)) else $error("access before recovery");
  a_reset_ready_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(cmd_ready) && $past(s_r.st) == S_RST |-> $past(rb_s, 1) && $past(rb_s, 2))
    else $error("left reset while busy");

endmodule

// ---- tb/fbm_flash_model.sv ----
// Purpose: behavioural flash device facing the host controller
// Assumes: command words equal the host's default parameters
// Notes:   floated data lines show the inverse of the last word

module fbm_flash_model
  import fbm_pkg::*;
#(
  parameter int          BUSY_NS  = 3000,
  parameter int          READY_NS = 1000,
  parameter logic [15:0] ID_WORD  = 16'h5A3C, // arbitrary id value
  parameter logic [9:0]  PROT_SEC = 10'h3FF
) (
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic              lower_half_select_n,
  input  wire logic              output_gate_n,
  input  wire logic              write_strobe_n,
  input  wire logic              reset_n,
  input  wire logic              accel_high_voltage_en,
  input  wire logic [DATA_W-1:0] dq_o,
  input  wire logic              dq_oe,
  output logic      [DATA_W-1:0] dq_i,
  output logic                   ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // command words and state
  localparam logic [21:0] U1A = 22'h000001;
  localparam logic [21:0] U2A = 22'h000002;
  localparam logic [15:0] C_U1 = 16'h0001, C_U2 = 16'h0002, C_PROG = 16'h0003, C_ERASE = 16'h0004;
  localparam logic [15:0] C_SECT = 16'h0005, C_CHIP = 16'h0006, C_BYP = 16'h0007, C_AUTO = 16'h0008;

  logic [15:0] mem [logic [21:0]];
  bit          ers [logic [9:0]];
  logic [9:0]  esq [$];
  bit          chip_er, byp, auto, ok;
  int          cyc, pk, viol, n_wr;
  realtime     t_sel, t_adr, t_rst;
  logic [15:0] last = 16'h0000;
  logic [15:0] pd;
  logic [21:0] pa;
  event        start_op;
  wire         en = reset_n && !lower_half_select_n && !output_gate_n;

  function automatic logic [15:0] word(input logic [21:0] a);
    if (auto) return ID_WORD;
    if (mem.exists(a)) return mem[a];
    if (chip_er || ers.exists(a[21:12])) return 16'hFFFF;
    return a[15:0] ^ 16'hC3A5;
  endfunction

  task automatic go(input int k, input logic [21:0] a, input logic [15:0] d);
    if (k == 1 && a[21:12] == PROT_SEC && !accel_high_voltage_en) return;
    pk = k;
    pa = a;
    pd = d;
    -> start_op;
  endtask

  task automatic commit();
    if (pk == 1) mem[pa] = pd;
    if (pk == 3) begin
      chip_er = 1;
      mem.delete();
    end
    foreach (esq[i]) ers[esq[i]] = 1;
  endtask

  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    if (!ready_busy_n) begin
      if (d == C_SECT) esq.push_back(a[21:12]);
      return;
    end
    if (byp || accel_high_voltage_en) begin
      if (cyc == 1) go(1, a, d);
      cyc = (cyc == 0 && d == C_PROG) ? 1 : 0;
      return;
    end
    case (cyc)
      0: cyc = (a == U1A && d == C_U1) ? 1 : 0;
      1: cyc = (a == U2A && d == C_U2) ? 2 : 0;
      2: begin
        byp = byp || d == C_BYP;
        auto = auto || d == C_AUTO;
        cyc = d == C_ERASE ? 3 : d == C_PROG ? 6 : 0;
      end
      3: cyc = (a == U1A && d == C_U1) ? 4 : 0;
      4: cyc = (a == U2A && d == C_U2) ? 5 : 0;
      5: begin
        if (d == C_SECT) esq.push_back(a[21:12]);
        go(d == C_CHIP ? 3 : 2, a, d);
        cyc = 0;
      end
      default: begin
        go(1, a, d);
        cyc = 0;
      end
    endcase
  endtask

  // ==========================================================
  // bus side
  always @(lower_half_select_n) t_sel = $realtime;
  always @(flash_addr) t_adr = $realtime;
  always @(posedge reset_n) t_rst = $realtime;
  always @(negedge output_gate_n) if ($realtime - t_rst < RESET_RECOVERY_NS) viol++;
  // a read before both access times ran out sees garbage, never the stale word
  always #1 begin
    ok = en && $realtime - t_sel >= SELECT_ACCESS_NS && $realtime - t_adr >= SELECT_ACCESS_NS;
    if (ok) last = word(flash_addr);
    dq_i = dq_oe ? dq_o : (ok ? last : ~last);
  end
  always @(negedge write_strobe_n) if (reset_n === 1'b1) begin
    if (lower_half_select_n !== 1'b0 || output_gate_n !== 1'b1 || dq_oe !== 1'b1) viol++;
    n_wr++;
    wr(flash_addr, dq_o);
  end
  always @(negedge reset_n) begin
    cyc = 0;
    byp = 0;
    auto = 0;
  end

  // ==========================================================
  // embedded operation, ends early on reset
  initial begin
    ready_busy_n = 1'b1;
    forever begin
      @(start_op);
      ready_busy_n = 1'b0;
      fork
        #(BUSY_NS) commit();
        @(negedge reset_n) #(READY_NS);
      join_any
      disable fork;
      esq.delete();
      ready_busy_n = 1'b1;
    end
  end
endmodule

// ---- tb/tb_flash_bus_mode_control.sv ----
// Purpose: self-checking bench for the flash bus mode host
// Assumes: flash model built with the host's default command words
// Notes:   model busy time is short to bound the run

module tb_flash_bus_mode_control
  import fbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic              clk, rst, cmd_valid, cmd_ready, accel_req, rsp_valid;
  logic [3:0]        cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, dq_o, dq_i, got;
  logic              autosel_active, reissue_hint, accel_high_voltage_en, lower_half_select_n;
  logic              output_gate_n, write_strobe_n, reset_n, dq_oe, ready_busy_n;
  int                n_errors, n_compared, seed;
  logic [15:0]       sh [logic [21:0]];

  fbm_host i_fbm_host (
    .clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .accel_req, .rsp_valid,
    .rsp_data, .autosel_active, .reissue_hint, .accel_high_voltage_en, .flash_addr,
    .lower_half_select_n, .output_gate_n, .write_strobe_n, .reset_n, .dq_o, .dq_oe, .dq_i, .ready_busy_n
  );
  fbm_flash_model i_fbm_flash_model (
    .flash_addr, .lower_half_select_n, .output_gate_n, .write_strobe_n, .reset_n,
    .accel_high_voltage_en, .dq_o, .dq_oe, .dq_i, .ready_busy_n
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // checks and drivers
  task automatic fail(input string m);
    n_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk_d(input logic [15:0] g, input logic [15:0] e, input string m);
    n_compared++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic chk_b(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [15:0] exp_w(input logic [21:0] a);
    return sh.exists(a) ? sh[a] : a[15:0] ^ 16'hC3A5;
  endfunction

  // one extra edge after accept so either ready timing reads as busy
  task automatic do_op(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    got = 'x;
    @(posedge clk);
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(negedge clk); while (cmd_ready !== 1'b1 && ++n < 9000);
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    do begin
      @(negedge clk);
      if (rsp_valid === 1'b1) got = rsp_data;
    end while (cmd_ready !== 1'b1 && ++n < 9000);
    if (n >= 9000) fail("request hung");
  endtask
  task automatic rd(input logic [21:0] a, input logic [15:0] e);
    do_op(OP_READ, a, 16'h0000);
    chk_d(got, e, "read data");
  endtask
  task automatic prog(input logic [21:0] a, input logic [15:0] d, input int cyc);
    int w;
    w = i_fbm_flash_model.n_wr;
    do_op(OP_PROG, a, d);
    chk_d(16'(i_fbm_flash_model.n_wr - w), 16'(cyc), "write cycles");
    sh[a] = d;
  endtask

  // ==========================================================
  // tests
  initial begin
    logic [21:0] a;
    logic [15:0] d;
    seed = 32'h611E4817;
    {n_errors, n_compared} = '0;
    {rst, cmd_valid, accel_req, cmd_op, cmd_addr, cmd_data} = {3'b100, 42'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) begin
      a = 22'($random(seed));
      rd(a, exp_w(a));
    end
    $display("test array read done");
    repeat (3) begin
      a = {2'b01, 20'($random(seed))};
      prog(a, 16'($random(seed)), 4);
      rd(a, sh[a]);
    end
    $display("test program done");
    do_op(OP_ERASE_SECT, 22'h001000, 16'h0000);
    do_op(OP_ERASE_ADD, 22'h002000, 16'h0000);
    rd(22'h001ABC, 16'hFFFF);
    rd(22'h002123, 16'hFFFF);
    rd(22'h003123, exp_w(22'h003123));
    $display("test sector erase done");
    do_op(OP_BYPASS, 22'h000000, 16'h0000);
    a = {2'b10, 20'($random(seed))};
    prog(a, 16'($random(seed)), 2);
    rd(a, sh[a]);
    do_op(OP_RESET, 22'h000000, 16'h0000);
    chk_b(reissue_hint, 1'b0, "idle reset hint");
    prog(a + 22'h1, 16'($random(seed)), 4);
    $display("test bypass done");
    do_op(OP_AUTOSEL, 22'h000000, 16'h0000);
    chk_b(autosel_active, 1'b1, "autoselect flag");
    rd(22'($random(seed)), i_fbm_flash_model.ID_WORD);
    do_op(OP_RESET, 22'h000000, 16'h0000);
    chk_b(autosel_active, 1'b0, "autoselect cleared");
    rd(a, sh[a]);
    $display("test autoselect done");
    @(posedge clk);
    accel_req <= 1'b1;
    repeat (8) @(negedge clk);
    chk_b(accel_high_voltage_en, 1'b1, "accel pin on");
    a = {10'h3FF, 12'($random(seed))};
    prog(a, 16'($random(seed)), 2);
    rd(a, sh[a]);
    @(posedge clk);
    accel_req <= 1'b0;
    repeat (8) @(negedge clk);
    chk_b(accel_high_voltage_en, 1'b0, "accel pin off");
    prog(a - 22'h1, 16'($random(seed)), 4);
    $display("test accelerate done");
    // keep clear of the protected sector so the program really starts
    a = {3'b110, 19'($random(seed))};
    d = 16'($random(seed));
    do_op(OP_PROG, a, d);
    do_op(OP_RESET, 22'h000000, 16'h0000);
    chk_b(reissue_hint, 1'b1, "reissue hint");
    rd(a, exp_w(a));
    prog(a, d, 4);
    rd(a, d);
    $display("test reset abort done");
    do_op(OP_ERASE_CHIP, 22'h000000, 16'h0000);
    rd(a, 16'hFFFF);
    chk_d(16'(i_fbm_flash_model.viol), 16'h0000, "pin protocol");
    $display("test chip erase done");
    finish_test();
  end

  initial begin
    #(600_000);
    fail("watchdog");
    finish_test();
  end
endmodule
